//--- hw/control_tick_decimator.v
/*
  Control tick decimator: prescaled PWM time base, event-trigger prescaler
  starting conversions, interrupt tick on end of conversion, and cascaded
  controller, current, estimator, speed and trajectory tick dividers, with
  a plain register port and a sticky-status interrupt.
  Assumes CLK is the root clock and all inputs are synchronous to it.
*/
`include "tick_tree_map.vh"

module control_tick_decimator #(
  parameter CLK_MHZ = `ROOT_FAST_MHZ,
  parameter W = 16
) (
  input wire CLK,
  input wire RST_B,
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  input wire EOC,
  input wire ALT_IRQ,
  input wire ISR_DONE,
  output reg SOC,
  output reg PWM_EVENT,
  output reg ISR_TICK,
  output reg CTRL_TICK,
  output reg CURRENT_TICK,
  output reg EST_TICK,
  output reg SPEED_TICK,
  output reg TRAJ_TICK,
  output reg IRQ
);

  // Root clock is OK at the fast rate or at any rate up to the slow one
  localparam ROOT_OK = (CLK_MHZ == `ROOT_FAST_MHZ) || (CLK_MHZ <= `ROOT_SLOW_MHZ);

  // Divider step: count up, wrap at ratio; ratio 0 treated as 1
  function [W:0] div_step;
    input [W-1:0] cnt;
    input [W-1:0] ratio;
    input en;
    begin
      div_step = {1'b0, cnt};
      if (en) begin
        if (cnt + 1'b1 >= ratio || ratio == {W{1'b0}})
          div_step = {1'b1, {W{1'b0}}};
        else
          div_step = {1'b0, cnt + 1'b1};
      end
    end
  endfunction

  reg run;
  reg use_alt;
  reg [W-1:0] pwm_period_value;
  reg [W-1:0] prescale;
  reg [1:0] event_trigger_prescale;
  reg [W-1:0] isr_to_control_ratio;
  reg [W-1:0] control_to_current_ratio;
  reg [W-1:0] control_to_estimator_ratio;
  reg [W-1:0] control_to_speed_ratio;
  reg [W-1:0] control_to_trajectory_ratio;
  reg [`EV_WIDTH-1:0] status;
  reg [`EV_WIDTH-1:0] mask;

  reg [W-1:0] pre_cnt;
  reg [W-1:0] tb_cnt;
  reg [1:0] et_cnt;
  reg [W-1:0] isr_cnt;
  reg [W-1:0] cur_cnt;
  reg [W-1:0] est_cnt;
  reg [W-1:0] spd_cnt;
  reg [W-1:0] trj_cnt;
  reg busy;
  reg [7:0] ctrl_count;

  wire [W:0] next_pre = div_step(pre_cnt, prescale, run);
  wire tb_en = next_pre[W];
  wire [W:0] next_tb = div_step(tb_cnt, pwm_period_value, tb_en);
  wire pwm_ev = next_tb[W];
  wire event_trigger_prescale_ok = (event_trigger_prescale != 2'h0);
  wire [W:0] next_et = div_step({{(W-2){1'b0}}, et_cnt},
    {{(W-2){1'b0}}, event_trigger_prescale}, pwm_ev && event_trigger_prescale_ok);
  wire soc_ev = next_et[W] && !use_alt;
  wire isr_ev = run && (use_alt ? ALT_IRQ : EOC);
  wire [W:0] next_isr = div_step(isr_cnt, isr_to_control_ratio, isr_ev);
  wire ctrl_ev = next_isr[W];
  wire [W:0] next_cur = div_step(cur_cnt, control_to_current_ratio, ctrl_ev);
  wire [W:0] next_est = div_step(est_cnt, control_to_estimator_ratio, ctrl_ev);
  wire [W:0] next_spd = div_step(spd_cnt, control_to_speed_ratio, ctrl_ev);
  wire [W:0] next_trj = div_step(trj_cnt, control_to_trajectory_ratio, ctrl_ev);
  // Tick arriving while host still busy means lost samples
  wire overrun_ev = isr_ev && busy && !ISR_DONE;
  wire badratio_ev = WR && (ADDR == `REG_EVENT_TRIGGER_PRESCALE_RATIO) && (WDATA[1:0] == 2'h0);

  wire [`EV_WIDTH-1:0] events = {badratio_ev, overrun_ev, next_trj[W], next_spd[W],
    next_est[W], next_cur[W], ctrl_ev, isr_ev, soc_ev, pwm_ev};
  wire status_wr = WR && (ADDR == `REG_STATUS);
  // Set wins over write-one-to-clear
  wire [`EV_WIDTH-1:0] next_status =
    (status & ~(status_wr ? WDATA[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}})) | events;

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      run <= 1'b0;
      use_alt <= 1'b0;
      pwm_period_value <= `RST_PERIOD;
      prescale <= `RST_PRESCALE;
      event_trigger_prescale <= `RST_EVENT_TRIGGER_PRESCALE;
      isr_to_control_ratio <= `RST_ISR_CTRL;
      control_to_current_ratio <= `RST_CTRL_CUR;
      control_to_estimator_ratio <= `RST_CTRL_EST;
      control_to_speed_ratio <= `RST_CTRL_SPD;
      control_to_trajectory_ratio <= `RST_CTRL_TRJ;
      mask <= {`EV_WIDTH{1'b0}};
    end else if (WR) begin
      case (ADDR)
        `REG_CTRL: begin
          run <= WDATA[`CTRL_RUN_BIT];
          use_alt <= WDATA[`CTRL_ALT_BIT];
        end
        `REG_PWM_PERIOD: pwm_period_value <= WDATA[W-1:0];
        `REG_PRESCALE: prescale <= WDATA[W-1:0];
        `REG_EVENT_TRIGGER_PRESCALE_RATIO: begin
          // Only 1, 2 or 3 accepted; a zero write is refused
          if (WDATA[1:0] != 2'h0)
            event_trigger_prescale <= WDATA[1:0];
        end
        `REG_ISR_CTRL: isr_to_control_ratio <= WDATA[W-1:0];
        `REG_CTRL_CUR: control_to_current_ratio <= WDATA[W-1:0];
        `REG_CTRL_EST: control_to_estimator_ratio <= WDATA[W-1:0];
        `REG_CTRL_SPD: control_to_speed_ratio <= WDATA[W-1:0];
        `REG_CTRL_TRJ: control_to_trajectory_ratio <= WDATA[W-1:0];
        `REG_MASK: mask <= WDATA[`EV_WIDTH-1:0];
        default: begin
        end
      endcase
    end
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pre_cnt <= {W{1'b0}};
      tb_cnt <= {W{1'b0}};
      et_cnt <= 2'h0;
      isr_cnt <= {W{1'b0}};
      cur_cnt <= {W{1'b0}};
      est_cnt <= {W{1'b0}};
      spd_cnt <= {W{1'b0}};
      trj_cnt <= {W{1'b0}};
      busy <= 1'b0;
      ctrl_count <= 8'h00;
      status <= {`EV_WIDTH{1'b0}};
      SOC <= 1'b0;
      PWM_EVENT <= 1'b0;
      ISR_TICK <= 1'b0;
      CTRL_TICK <= 1'b0;
      CURRENT_TICK <= 1'b0;
      EST_TICK <= 1'b0;
      SPEED_TICK <= 1'b0;
      TRAJ_TICK <= 1'b0;
      IRQ <= 1'b0;
      RDATA <= 32'h0;
    end else begin
      // Stopping clears the chain so a restart is phase-aligned
      pre_cnt <= run ? next_pre[W-1:0] : {W{1'b0}};
      tb_cnt <= run ? next_tb[W-1:0] : {W{1'b0}};
      et_cnt <= run ? next_et[1:0] : 2'h0;
      isr_cnt <= run ? next_isr[W-1:0] : {W{1'b0}};
      cur_cnt <= run ? next_cur[W-1:0] : {W{1'b0}};
      est_cnt <= run ? next_est[W-1:0] : {W{1'b0}};
      spd_cnt <= run ? next_spd[W-1:0] : {W{1'b0}};
      trj_cnt <= run ? next_trj[W-1:0] : {W{1'b0}};
      busy <= isr_ev | (busy & ~ISR_DONE);
      if (ctrl_ev)
        ctrl_count <= ctrl_count + 8'h01;
      status <= next_status;
      SOC <= soc_ev;
      PWM_EVENT <= pwm_ev;
      ISR_TICK <= isr_ev;
      CTRL_TICK <= ctrl_ev;
      CURRENT_TICK <= next_cur[W];
      EST_TICK <= next_est[W];
      SPEED_TICK <= next_spd[W];
      TRAJ_TICK <= next_trj[W];
      IRQ <= |(next_status & mask);
      RDATA <= 32'h0;
      if (RD) begin
        case (ADDR)
          `REG_CTRL: RDATA <= {30'h0, use_alt, run};
          `REG_PWM_PERIOD: RDATA[W-1:0] <= pwm_period_value;
          `REG_PRESCALE: RDATA[W-1:0] <= prescale;
          `REG_EVENT_TRIGGER_PRESCALE_RATIO: RDATA[1:0] <= event_trigger_prescale;
          `REG_ISR_CTRL: RDATA[W-1:0] <= isr_to_control_ratio;
          `REG_CTRL_CUR: RDATA[W-1:0] <= control_to_current_ratio;
          `REG_CTRL_EST: RDATA[W-1:0] <= control_to_estimator_ratio;
          `REG_CTRL_SPD: RDATA[W-1:0] <= control_to_speed_ratio;
          `REG_CTRL_TRJ: RDATA[W-1:0] <= control_to_trajectory_ratio;
          `REG_STATUS: RDATA[`EV_WIDTH-1:0] <= status;
          `REG_MASK: RDATA[`EV_WIDTH-1:0] <= mask;
          `REG_COUNTS: RDATA <= {ctrl_count, 6'h00, busy, ROOT_OK[0], tb_cnt};
          default: RDATA <= 32'h0;
        endcase
      end
    end
  end

endmodule // control_tick_decimator

//--- hw/tick_tree_map.vh
/*
  Offsets, field positions, reset values and timing figures of the control
  tick tree. Assumes inclusion by bare name from the design module.
*/
`ifndef TICK_TREE_MAP_VH
`define TICK_TREE_MAP_VH

// Register word offsets (byte address = offset)
`define REG_CTRL        8'h00
`define REG_PWM_PERIOD  8'h04
`define REG_PRESCALE    8'h08
`define REG_EVENT_TRIGGER_PRESCALE_RATIO  8'h0c
`define REG_ISR_CTRL    8'h10
`define REG_CTRL_CUR    8'h14
`define REG_CTRL_EST    8'h18
`define REG_CTRL_SPD    8'h1c
`define REG_CTRL_TRJ    8'h20
`define REG_STATUS      8'h24
`define REG_MASK        8'h28
`define REG_COUNTS      8'h2c

// Control register fields
`define CTRL_RUN_BIT    0
`define CTRL_ALT_BIT    1

// Status / mask bit positions
`define EV_PWM          0
`define EV_SOC          1
`define EV_ISR          2
`define EV_CTRL         3
`define EV_CUR          4
`define EV_EST          5
`define EV_SPD          6
`define EV_TRJ          7
`define EV_OVERRUN      8
`define EV_BADRATIO     9
`define EV_WIDTH        10

// Reset values
`define RST_PRESCALE    16'h0001
`define RST_PERIOD      16'h0959
`define RST_EVENT_TRIGGER_PRESCALE        2'h1
`define RST_ISR_CTRL    16'h0001
`define RST_CTRL_CUR    16'h0001
`define RST_CTRL_EST    16'h0001
`define RST_CTRL_SPD    16'h000a
`define RST_CTRL_TRJ    16'h000a

// Root clock figures, MHz
`define ROOT_FAST_MHZ   90
`define ROOT_SLOW_MHZ   60

`endif

//--- sim/control_tick_decimator_properties.sv
/*
  Checker of the tick tree outputs against their causes at the ports.
  Assumes it is bound to the decimator and that ratios change only while stopped.
*/
`include "tick_tree_map.vh"

module control_tick_decimator_properties (
  input wire CLK,
  input wire RST_B,
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [31:0] RDATA,
  input wire EOC,
  input wire ALT_IRQ,
  input wire SOC,
  input wire PWM_EVENT,
  input wire ISR_TICK,
  input wire CTRL_TICK,
  input wire CURRENT_TICK,
  input wire EST_TICK,
  input wire SPEED_TICK,
  input wire TRAJ_TICK,
  input wire IRQ
);
  reg [15:0] spd_ratio;
  reg [15:0] spd_cnt;
  reg run_s;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // Shadow of the speed divider; stopping the run clears it
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      spd_ratio <= `RST_CTRL_SPD;
      spd_cnt <= 16'h0000;
      run_s <= 1'b0;
    end else begin
      if (WR && ADDR == `REG_CTRL_SPD) spd_ratio <= WDATA[15:0];
      if (WR && ADDR == `REG_CTRL) run_s <= WDATA[0];
      // Divider clears one edge after the run bit drops, as in the design
      if (!run_s) spd_cnt <= 16'h0000;
      else if (CTRL_TICK) spd_cnt <= SPEED_TICK ? 16'h0000 : spd_cnt + 16'h0001;
    end
  end
  a_isr_cause: assert property (ISR_TICK |-> $past(EOC) || $past(ALT_IRQ))
    else $error("interrupt tick without end of conversion");
  a_soc_cause: assert property (SOC |-> PWM_EVENT || $past(PWM_EVENT))
    else $error("conversion start without PWM event");
  a_ctrl_isr: assert property (CTRL_TICK |-> ISR_TICK)
    else $error("controller tick without interrupt tick");
  a_cur_ctrl: assert property (CURRENT_TICK |-> CTRL_TICK)
    else $error("current tick without controller tick");
  a_est_ctrl: assert property (EST_TICK |-> CTRL_TICK)
    else $error("estimator tick without controller tick");
  a_spd_ctrl: assert property (SPEED_TICK |-> CTRL_TICK)
    else $error("speed tick without controller tick");
  a_trj_ctrl: assert property (TRAJ_TICK |-> CTRL_TICK)
    else $error("trajectory tick without controller tick");
  a_speed_period: assert property (CTRL_TICK |->
      SPEED_TICK == (spd_cnt + 16'h0001 >= (spd_ratio == 16'h0000 ? 16'h0001 : spd_ratio)))
    else $error("speed tick off its period");
  a_read_idle: assert property (!$past(RD) |-> RDATA == 32'h00000000)
    else $error("read data outside read slot");
  c_speed: cover property (SPEED_TICK);
  c_traj: cover property (TRAJ_TICK && CTRL_TICK);
  c_irq: cover property (IRQ);
endmodule // control_tick_decimator_properties

bind control_tick_decimator control_tick_decimator_properties u_props (.CLK(CLK), .RST_B(RST_B),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .EOC(EOC), .ALT_IRQ(ALT_IRQ),
  .SOC(SOC), .PWM_EVENT(PWM_EVENT), .ISR_TICK(ISR_TICK), .CTRL_TICK(CTRL_TICK),
  .CURRENT_TICK(CURRENT_TICK), .EST_TICK(EST_TICK), .SPEED_TICK(SPEED_TICK),
  .TRAJ_TICK(TRAJ_TICK), .IRQ(IRQ));

//--- sim/test_control_tick_decimator.sv
/*
  Self-checking bench of the tick decimator with converter and service model.
  Assumes the register map header and a 100 MHz clock.
*/
`include "tick_tree_map.vh"

module test_control_tick_decimator;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0, RST_B = 0, WR = 0, RD = 0, slow = 0, alt_en = 0, rd_d = 0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, seed = 32'hfb34cd85, exp_q[$], msk_q[$];
  logic [31:0] r[6], dflt[8] = '{32'h959, 1, 1, 1, 1, 1, 32'ha, 32'ha};
  wire [31:0] RDATA;
  wire EOC, ALT_IRQ, ISR_DONE, SOC, PWM_EVENT, ISR_TICK, CTRL_TICK, IRQ;
  wire CURRENT_TICK, EST_TICK, SPEED_TICK, TRAJ_TICK;
  int error_cnt = 0, checks_done = 0, i, s, b, n[8] = '{default: 0};
  always #5 CLK = ~CLK;
  control_tick_decimator u_control_tick_decimator (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .EOC(EOC), .ALT_IRQ(ALT_IRQ),
    .ISR_DONE(ISR_DONE), .SOC(SOC), .PWM_EVENT(PWM_EVENT), .ISR_TICK(ISR_TICK),
    .CTRL_TICK(CTRL_TICK), .CURRENT_TICK(CURRENT_TICK), .EST_TICK(EST_TICK),
    .SPEED_TICK(SPEED_TICK), .TRAJ_TICK(TRAJ_TICK), .IRQ(IRQ));
  tick_partner u_tick_partner (.clk(CLK), .rst_b(RST_B), .soc(SOC), .isr_tick(ISR_TICK),
    .slow(slow), .alt_en(alt_en), .eoc(EOC), .isr_done(ISR_DONE), .alt_irq(ALT_IRQ));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a; WDATA <= d; WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge CLK);
    ADDR <= a; RD <= 1'b1;
    exp_q.push_back(e & m); msk_q.push_back(m);
    @(posedge CLK);
    RD <= 1'b0;
  endtask
  // Reads are judged in the slot after the strobe, oldest note first
  always @(posedge CLK) begin
    if (rd_d) begin
      chk(RDATA & msk_q[0], exp_q[0]);
      void'(exp_q.pop_front()); void'(msk_q.pop_front());
    end
    rd_d <= RD;
    foreach (n[k]) n[k] += ({TRAJ_TICK, SPEED_TICK, EST_TICK, CURRENT_TICK, CTRL_TICK,
      ISR_TICK, SOC, PWM_EVENT} >> k) & 1;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1;
    for (i = 0; i < 8; i++) rd(8'h04 + 8'(4 * i), dflt[i], '1);
    wr(8'h3c, '1);
    rd(8'h3c, 0, '1);
    $display("test defaults done");
    for (i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      r[i] = (i == 0) ? seed % 3 + 1 : seed % 4 + 1;
      wr(8'h0c + 8'(4 * i), r[i]);
    end
    wr(`REG_PWM_PERIOD, 32'h8);
    wr(`REG_EVENT_TRIGGER_PRESCALE_RATIO, 0);
    rd(`REG_EVENT_TRIGGER_PRESCALE_RATIO, r[0], '1);
    rd(`REG_STATUS, 32'h200, 32'h200);
    wr(`REG_MASK, 32'h4);
    wr(`REG_CTRL, 1);
    repeat (1500) @(posedge CLK);
    wr(`REG_CTRL, 0);
    repeat (6) @(posedge CLK);
    chk(n[1], n[0] / r[0]);
    chk(n[0] >= 185 && n[0] <= 190, 1);
    chk(n[3], n[2] / r[1]);
    for (i = 0; i < 4; i++) chk(n[4 + i], n[3] / r[2 + i]);
    chk(IRQ, 1);
    rd(`REG_STATUS, 0, 32'h100);
    wr(`REG_STATUS, '1);
    rd(`REG_STATUS, 0, '1);
    chk(IRQ, 0);
    $display("test prompt run done");
    s = n[1];
    b = n[2];
    slow <= 1'b1; alt_en <= 1'b1;
    wr(`REG_CTRL, 3);
    repeat (400) @(posedge CLK);
    wr(`REG_CTRL, 0);
    chk(n[1] - s, 0);
    chk(n[2] > b + 5, 1);
    rd(`REG_STATUS, 32'h100, 32'h100);
    chk(IRQ, 1);
    wr(`REG_MASK, 0);
    repeat (2) @(posedge CLK);
    chk(IRQ, 0);
    $display("test alternate slow run done");
    repeat (3) @(posedge CLK);
    complete_run();
  end
endmodule // test_control_tick_decimator

//--- sim/tick_partner.sv
/*
  Converter and interrupt service model at the far side of the tick tree.
  Assumes one clock; slow mode withholds the service acknowledge.
*/
module tick_partner (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic soc,
  input wire logic isr_tick,
  input wire logic slow,
  input wire logic alt_en,
  output logic eoc,
  output logic isr_done,
  output logic alt_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] conv;
  logic [1:0] serv;
  logic [4:0] alt_cnt;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv <= 3'h0;
      serv <= 2'h0;
      alt_cnt <= 5'h00;
    end else begin
      conv <= {conv[1:0], soc};
      serv <= {serv[0], isr_tick & !slow};
      alt_cnt <= alt_cnt + 5'h01;
    end
  end
  assign eoc = conv[2];
  assign isr_done = serv[1]; // Prompt work ends well inside one period
  assign alt_irq = alt_en && alt_cnt == 5'h00; // Fixed period
endmodule // tick_partner
